/* File: hdl/jtapm_pkg.sv */
/*
 * Constants, TAP state type and decode helpers for the test access port.
 * Assumes a single system clock domain samples all test pins.
 */
package jtapm_pkg;

    localparam int         IR_W          = 4;
    localparam logic [3:0] IR_CAPTURE    = 4'h1;
    localparam logic [3:0] INSTR_EXTEST  = 4'h0;
    localparam logic [3:0] INSTR_INTEST  = 4'h1;
    localparam logic [3:0] INSTR_SAMPLE  = 4'h2;
    localparam logic [3:0] INSTR_ABORT   = 4'h8;
    localparam logic [3:0] DEBUG_PORT_ACCESS_INSTR  = 4'hA;
    localparam logic [3:0] ACCESS_PORT_ACCESS_INSTR = 4'hB;
    localparam logic [3:0] INSTR_IDCODE  = 4'hE;
    localparam logic [3:0] INSTR_BYPASS  = 4'hF;
    localparam int         ID_W          = 32;
    localparam int         BSR_W_DEF     = 8;
    localparam int         FIFO_DEPTH    = 16;
    localparam logic       ALT_FUNC_RST  = 1'b1;
    localparam logic [2:0] TMS_RESET_CNT = 3'h5;
    localparam logic [5:0] SYNC_RST      = 6'h0F; // tck, tms, tdi and trst_n idle at their pull-up level; core_tdo idles low

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } jtapm_state_t;

    function automatic jtapm_state_t jtapm_next(input jtapm_state_t s, input logic tms);
        unique case (s)
            TLR:      jtapm_next = tms ? TLR      : RTI;
            RTI:      jtapm_next = tms ? SEL_DR   : RTI;
            SEL_DR:   jtapm_next = tms ? SEL_IR   : CAP_DR;
            CAP_DR:   jtapm_next = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: jtapm_next = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: jtapm_next = tms ? UPD_DR   : PAUSE_DR;
            PAUSE_DR: jtapm_next = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: jtapm_next = tms ? UPD_DR   : SHIFT_DR;
            UPD_DR:   jtapm_next = tms ? SEL_DR   : RTI;
            SEL_IR:   jtapm_next = tms ? TLR      : CAP_IR;
            CAP_IR:   jtapm_next = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: jtapm_next = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: jtapm_next = tms ? UPD_IR   : PAUSE_IR;
            PAUSE_IR: jtapm_next = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: jtapm_next = tms ? UPD_IR   : SHIFT_IR;
            UPD_IR:   jtapm_next = tms ? SEL_DR   : RTI;
        endcase
    endfunction

    // Unknown codes fall back to the bypass path
    function automatic logic [3:0] jtapm_decode(input logic [3:0] ir);
        unique case (ir)
            INSTR_EXTEST, INSTR_INTEST, INSTR_SAMPLE, INSTR_ABORT,
            DEBUG_PORT_ACCESS_INSTR, ACCESS_PORT_ACCESS_INSTR, INSTR_IDCODE: jtapm_decode = ir;
            default:                                jtapm_decode = INSTR_BYPASS;
        endcase
    endfunction

    function automatic logic jtapm_is_core(input logic [3:0] ir);
        jtapm_is_core = (ir == INSTR_ABORT) || (ir == DEBUG_PORT_ACCESS_INSTR) || (ir == ACCESS_PORT_ACCESS_INSTR);
    endfunction

endpackage

/* File: hdl/jtapm_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes both sides run on clk; rst is synchronous, active high.
 */
`timescale 1ns/100ps
module jtapm_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp_q;
    logic [AW:0]  wp_d;
    logic [AW:0]  rp_q;
    logic [AW:0]  rp_d;
    logic         push;
    logic         pop;

    assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign out_valid = wp_q != rp_q;
    assign out_data  = mem[rp_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end

endmodule

/* File: hdl/jtapm_tap.sv */
/*
 * Test access port: TAP state machine, four-bit instruction chain,
 * bypass, identification and boundary chains, and the TDO multiplexer
 * shared with the core debug port. Preload updates stream out via a FIFO.
 * Assumes tck, tms, tdi, trst_n and core_tdo come from outside the clk
 * domain and that tck is much slower than clk.
 */
`timescale 1ns/100ps
module jtapm_tap #(
    parameter int          BSR_W        = jtapm_pkg::BSR_W_DEF,
    parameter int          DEPTH        = jtapm_pkg::FIFO_DEPTH,
    parameter logic [31:0] IDCODE_VALUE = 32'h0000_1001 // Arbitrary value
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    input  wire logic             trst_n,
    input  wire logic             core_tdo,
    output logic                  tdo,
    output logic                  tdo_oe,
    output logic                  core_tdo_sel,
    input  wire logic [BSR_W-1:0] pin_sample,
    output logic [BSR_W-1:0]      bsr_out,
    output logic                  extest_en,
    output logic                  intest_en,
    input  wire logic             alt_func_wr,
    input  wire logic             alt_func_wdata,
    input  wire logic             lock_open,
    input  wire logic             commit_en,
    output logic                  alt_function_select_bit,
    output logic                  upd_valid,
    input  wire logic             upd_ready,
    output logic [BSR_W-1:0]      upd_data,
    output logic                  upd_refused
);
    import jtapm_pkg::*;

    logic [5:0]       sync1_q;
    logic [5:0]       sync2_q;
    logic             tck_prev_q;
    logic             tck_s;
    logic             tms_s;
    logic             tdi_s;
    logic             trst_s;
    logic             core_s;
    logic             rise;
    logic             fall;

    jtapm_state_t     state_q;
    jtapm_state_t     state_d;
    logic [IR_W-1:0]  ir_q;
    logic [IR_W-1:0]  ir_d;
    logic [IR_W-1:0]  ir_sh_q;
    logic [IR_W-1:0]  ir_sh_d;
    logic             byp_q;
    logic             byp_d;
    logic [ID_W-1:0]  id_sh_q;
    logic [ID_W-1:0]  id_sh_d;
    logic [BSR_W-1:0] bsr_sh_q;
    logic [BSR_W-1:0] bsr_sh_d;
    logic [BSR_W-1:0] bsr_upd_q;
    logic [BSR_W-1:0] bsr_upd_d;
    logic             refused_q;
    logic             refused_d;
    logic             alt_func_q;
    logic             alt_func_d;
    logic [3:0]       instr;
    logic             fifo_ready;
    logic             push;

    logic             tdo_q;
    logic             tdo_d;
    logic             oe_q;
    logic             oe_d;
    logic             csel_q;
    logic             csel_d;

    // Pin synchronisers; only stage two is read
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q    <= SYNC_RST;
            sync2_q    <= SYNC_RST;
            tck_prev_q <= SYNC_RST[0];
        end else begin
            sync1_q    <= {1'b0, core_tdo, trst_n, tdi, tms, tck};
            sync2_q    <= sync1_q;
            tck_prev_q <= sync2_q[0];
        end
    end

    assign tck_s  = sync2_q[0];
    assign tms_s  = sync2_q[1];
    assign tdi_s  = sync2_q[2];
    assign trst_s = sync2_q[3];
    assign core_s = sync2_q[4];
    assign rise   = tck_s && !tck_prev_q;
    assign fall   = !tck_s && tck_prev_q;
    assign instr  = jtapm_decode(ir_q);
    assign push   = rise && (state_q == UPD_DR) && (instr == INSTR_SAMPLE) && fifo_ready
                    && trst_s && alt_func_q;

    always_comb begin
        state_d   = state_q;
        ir_d      = ir_q;
        ir_sh_d   = ir_sh_q;
        byp_d     = byp_q;
        id_sh_d   = id_sh_q;
        bsr_sh_d  = bsr_sh_q;
        bsr_upd_d = bsr_upd_q;
        refused_d = refused_q;
        alt_func_d = alt_func_q;
        if (alt_func_wr && lock_open && commit_en) begin
            alt_func_d = alt_func_wdata;
        end
        if (!trst_s || !alt_func_q) begin
            state_d = TLR;
        end else if (rise) begin
            state_d = jtapm_next(state_q, tms_s);
            unique case (state_q)
                CAP_IR:   ir_sh_d = IR_CAPTURE;
                SHIFT_IR: ir_sh_d = {tdi_s, ir_sh_q[IR_W-1:1]};
                UPD_IR:   ir_d = ir_sh_q;
                default:  ;
            endcase
            unique case (state_q)
                CAP_DR: begin
                    if (instr == INSTR_BYPASS) begin
                        byp_d = 1'b0;
                    end
                    if (instr == INSTR_IDCODE) begin
                        id_sh_d = IDCODE_VALUE;
                    end
                    if (instr == INSTR_SAMPLE) begin
                        bsr_sh_d = pin_sample;
                    end
                end
                SHIFT_DR: begin
                    if (instr == INSTR_BYPASS) begin
                        byp_d = tdi_s;
                    end
                    if (instr == INSTR_IDCODE) begin
                        id_sh_d = {tdi_s, id_sh_q[ID_W-1:1]};
                    end
                    if (instr == INSTR_SAMPLE) begin
                        bsr_sh_d = {tdi_s, bsr_sh_q[BSR_W-1:1]};
                    end
                end
                UPD_DR: begin
                    if (instr == INSTR_SAMPLE) begin
                        if (fifo_ready) begin
                            bsr_upd_d = bsr_sh_q;
                        end else begin
                            refused_d = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (state_d == TLR) begin
            ir_d = INSTR_IDCODE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q   <= TLR;
            ir_q      <= INSTR_IDCODE;
            ir_sh_q   <= '0;
            byp_q     <= 1'b0;
            id_sh_q   <= '0;
            bsr_sh_q  <= '0;
            bsr_upd_q <= '0;
            refused_q <= 1'b0;
            alt_func_q <= ALT_FUNC_RST;
        end else begin
            state_q   <= state_d;
            ir_q      <= ir_d;
            ir_sh_q   <= ir_sh_d;
            byp_q     <= byp_d;
            id_sh_q   <= id_sh_d;
            bsr_sh_q  <= bsr_sh_d;
            bsr_upd_q <= bsr_upd_d;
            refused_q <= refused_d;
            alt_func_q <= alt_func_d;
        end
    end

    // Serial output and enable, changed only on falling tck edges; core select follows ir_q every clk
    always_comb begin
        tdo_d  = tdo_q;
        oe_d   = oe_q;
        csel_d = jtapm_is_core(ir_q);
        if (fall) begin
            oe_d = alt_func_q && ((state_q == SHIFT_IR) || (state_q == SHIFT_DR));
            if (csel_q) begin
                tdo_d = core_s;
            end else if (state_q == SHIFT_IR) begin
                tdo_d = ir_sh_q[0];
            end else begin
                unique case (instr)
                    INSTR_IDCODE: tdo_d = id_sh_q[0];
                    INSTR_SAMPLE: tdo_d = bsr_sh_q[0];
                    INSTR_BYPASS: tdo_d = byp_q;
                    default:      tdo_d = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tdo_q  <= 1'b0;
            oe_q   <= 1'b0;
            csel_q <= 1'b0;
        end else begin
            tdo_q  <= tdo_d;
            oe_q   <= oe_d;
            csel_q <= csel_d;
        end
    end

    jtapm_fifo #(
        .W     (BSR_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (bsr_sh_q),
        .out_valid (upd_valid),
        .out_ready (upd_ready),
        .out_data  (upd_data)
    );

    assign tdo                     = tdo_q;
    assign tdo_oe                  = oe_q;
    assign core_tdo_sel            = csel_q;
    assign bsr_out                 = bsr_upd_q;
    assign extest_en               = (ir_q == INSTR_EXTEST);
    assign intest_en               = (ir_q == INSTR_INTEST);
    assign alt_function_select_bit = alt_func_q;
    assign upd_refused             = refused_q;

    // Helper: run of tck rises with tms high
    logic [2:0] tms_run_q;
    logic [2:0] tms_run_d;

    always_comb begin
        tms_run_d = tms_run_q;
        if (rise) begin
            tms_run_d = !tms_s ? 3'h0 : (tms_run_q == 3'h7 ? tms_run_q : tms_run_q + 3'h1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tms_run_q <= 3'h0;
        end else begin
            tms_run_q <= tms_run_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_sample_update;
        rise && (state_q == UPD_DR) && (instr == INSTR_SAMPLE) && trst_s && alt_func_q;
    endsequence

    sequence s_bypass_shift;
        rise && (state_q == SHIFT_DR) && (instr == INSTR_BYPASS) && trst_s && alt_func_q;
    endsequence

    a_trst_holds: assert property (!trst_s |=> state_q == TLR [*2] or !trst_s)
        else $error("TAP left reset while trst asserted");
    a_ir_default: assert property (state_q == TLR |-> ir_q == INSTR_IDCODE)
        else $error("IR not IDCODE in reset state");
    a_state_idle: assert property (!rise && trst_s && alt_func_q |=> $stable(state_q))
        else $error("TAP state moved without tck rise");
    a_tms_five: assert property (tms_run_q >= TMS_RESET_CNT |-> state_q == TLR)
        else $error("Five tms-high clocks did not reach reset");
    a_tdo_fall: assert property (!fall |=> $stable(tdo_q) && $stable(tdo_oe))
        else $error("TDO changed away from a falling edge");
    a_core_mux: assert property (fall && csel_q |=> tdo_q == $past(core_s))
        else $error("Core TDO not routed under core instruction");
    a_bypass_path: assert property (s_bypass_shift |=> byp_q == $past(tdi_s) ##1 1'b1)
        else $error("Bypass bit did not take TDI");
    a_update_load: assert property (s_sample_update and fifo_ready |=> bsr_upd_q == $past(bsr_sh_q) && upd_valid)
        else $error("Update state did not load preload register");
    a_ext_frozen: assert property ((extest_en || intest_en) && !$changed(ir_q) |=> $stable(bsr_sh_q) && $stable(bsr_upd_q))
        else $error("Chain changed under EXTEST or INTEST");
    a_commit_gate: assert property ($changed(alt_func_q) |-> $past(alt_func_wr && lock_open && commit_en))
        else $error("Pin function changed without commit");

endmodule

/* File: dv/jtapm_host.sv */
/*
 * Model of the external test host: drives tck, tms, tdi and trst_n, reads tdo.
 * Assumes clk is the device clock; one tck period spans 8 clk periods (320 ns).
 */
`timescale 1ns/100ps
module jtapm_host (
    input  wire logic clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    logic oe_all;

    initial begin
        tck    = 1'b1;
        tms    = 1'b1;
        tdi    = 1'b1;
        trst_n = 1'b1;
        oe_all = 1'b1;
    end

    // One tck period of 8 clk, called at a falling clk edge; tdo read mid high phase
    task automatic tick(input logic m, input logic d, output logic o);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        repeat (2) @(negedge clk);
        // Released tdo reads high through its pull-up
        o = tdo_oe ? tdo : 1'b1;
        repeat (2) @(negedge clk);
    endtask

    // From run-test-idle through capture, shift and update back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout   = '0;
        oe_all = 1'b1;
        tick(1'b1, 1'b1, o);
        if (ir) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
            oe_all  = oe_all & tdo_oe;
        end
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask

    task automatic set_trst(input logic v);
        @(negedge clk);
        trst_n = v;
        repeat (4) @(negedge clk);
    endtask
endmodule

/* File: dv/testbench.sv */
/*
 * Self-checking bench for the test access port with its update FIFO.
 * Assumes the host model drives the test pins; all else is driven here.
 */
`timescale 1ns/100ps
module testbench;
    import jtapm_pkg::*;
    localparam logic [31:0] ID = 32'h1357_9BDF; // Arbitrary value

    logic       clk, rst, tck, tms, tdi, trst_n, core_tdo, tdo, tdo_oe, core_tdo_sel;
    logic       extest_en, intest_en, alt_func_wr, alt_func_wdata, lock_open, commit_en;
    logic       alt_function_select_bit, upd_valid, upd_ready, upd_refused, o;
    logic [7:0] pin_sample, bsr_out, upd_data;
    logic [31:0] d;
    int         mismatches, n_compared;

    jtapm_host u_host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));

    jtapm_tap #(.BSR_W(8), .DEPTH(16), .IDCODE_VALUE(ID)) u_dut (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .core_tdo(core_tdo), .tdo(tdo), .tdo_oe(tdo_oe), .core_tdo_sel(core_tdo_sel),
        .pin_sample(pin_sample), .bsr_out(bsr_out), .extest_en(extest_en), .intest_en(intest_en),
        .alt_func_wr(alt_func_wr), .alt_func_wdata(alt_func_wdata), .lock_open(lock_open), .commit_en(commit_en),
        .alt_function_select_bit(alt_function_select_bit), .upd_valid(upd_valid),
        .upd_ready(upd_ready), .upd_data(upd_data), .upd_refused(upd_refused));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic ir(input logic [3:0] c);
        u_host.scan(1'b1, 4, {28'h0, c}, d);
    endtask

    task automatic t_idcode;
        u_host.tick(1'b0, 1'b1, o);
        u_host.scan(1'b1, 4, {28'h0, INSTR_IDCODE}, d);
        chk(d, {28'h0, IR_CAPTURE});
        chk(u_host.oe_all, 1'b1);
        u_host.tick(1'b0, 1'b1, o);
        chk(tdo_oe, 1'b0);
        u_host.scan(1'b0, 32, 32'h0, d);
        chk(d, ID);
        $display("idcode done");
    endtask

    task automatic t_bypass;
        logic [3:0] codes [4] = '{4'h3, 4'h5, 4'hC, INSTR_BYPASS};
        foreach (codes[k]) begin
            ir(codes[k]);
            u_host.scan(1'b0, 8, 32'hB6, d);
            chk(d, 32'h6C);
        end
        $display("bypass done");
    endtask

    task automatic t_core;
        logic [3:0] codes [3] = '{INSTR_ABORT, DEBUG_PORT_ACCESS_INSTR, ACCESS_PORT_ACCESS_INSTR};
        core_tdo = 1'b1;
        foreach (codes[k]) begin
            ir(codes[k]);
            chk(core_tdo_sel, 1'b1);
            u_host.scan(1'b0, 4, 32'h0, d);
            chk(d, 32'hF);
        end
        core_tdo = 1'b0;
        ir(INSTR_IDCODE);
        chk(core_tdo_sel, 1'b0);
        $display("core done");
    endtask

    task automatic t_ext;
        logic [3:0] codes [2] = '{INSTR_EXTEST, INSTR_INTEST};
        foreach (codes[k]) begin
            ir(codes[k]);
            chk(extest_en, codes[k] == INSTR_EXTEST);
            chk(intest_en, codes[k] == INSTR_INTEST);
            u_host.scan(1'b0, 8, 32'hFF, d);
            chk(d, 32'h0);
            chk(bsr_out, 8'h00);
            chk(upd_valid, 1'b0);
        end
        $display("extest done");
    endtask

    task automatic t_sample;
        ir(INSTR_SAMPLE);
        pin_sample = 8'hA5;
        for (int k = 0; k < 16; k++) begin
            u_host.scan(1'b0, 8, 32'h10 + k, d);
            chk(d, 32'hA5);
            chk(bsr_out, 8'h10 + k);
            chk(upd_valid, 1'b1);
        end
        u_host.scan(1'b0, 8, 32'hEE, d);
        chk(upd_refused, 1'b1);
        chk(bsr_out, 8'h1F);
        for (int k = 0; k < 16; k++) begin
            chk(upd_valid, 1'b1);
            chk(upd_data, 8'h10 + k);
            upd_ready = 1'b1;
            @(negedge clk);
            upd_ready = 1'b0;
            @(negedge clk);
        end
        chk(upd_valid, 1'b0);
        $display("sample done");
    endtask

    task automatic t_resets;
        ir(4'h5);
        repeat (5) u_host.tick(1'b1, 1'b1, o);
        u_host.tick(1'b0, 1'b1, o);
        u_host.scan(1'b0, 32, 32'h0, d);
        chk(d, ID);
        ir(4'h5);
        u_host.set_trst(1'b0);
        u_host.tick(1'b0, 1'b1, o);
        u_host.tick(1'b1, 1'b1, o);
        u_host.tick(1'b0, 1'b1, o);
        u_host.tick(1'b0, 1'b1, o);
        u_host.set_trst(1'b1);
        u_host.tick(1'b0, 1'b1, o);
        u_host.scan(1'b0, 32, 32'h0, d);
        chk(d, ID);
        $display("resets done");
    endtask

    task automatic afw(input logic v, input logic l, input logic c);
        @(negedge clk);
        alt_func_wdata = v;
        lock_open      = l;
        commit_en      = c;
        alt_func_wr    = 1'b1;
        @(negedge clk);
        alt_func_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic t_pins;
        ir(INSTR_SAMPLE);
        chk(alt_function_select_bit, 1'b1);
        afw(1'b0, 1'b1, 1'b0);
        chk(alt_function_select_bit, 1'b1);
        afw(1'b0, 1'b0, 1'b1);
        chk(alt_function_select_bit, 1'b1);
        afw(1'b0, 1'b1, 1'b1);
        chk(alt_function_select_bit, 1'b0);
        u_host.scan(1'b0, 8, 32'h0, d);
        chk(u_host.oe_all, 1'b0);
        chk(d, 32'hFF);
        afw(1'b1, 1'b1, 1'b1);
        chk(alt_function_select_bit, 1'b1);
        u_host.tick(1'b0, 1'b1, o);
        u_host.scan(1'b0, 32, 32'h0, d);
        chk(d, ID);
        $display("pins done");
    endtask

    initial begin
        mismatches = 0;
        n_compared = 0;
        rst = 1'b1;
        core_tdo = 1'b0;
        pin_sample = 8'h00;
        alt_func_wr = 1'b0;
        alt_func_wdata = 1'b0;
        lock_open = 1'b0;
        commit_en = 1'b0;
        upd_ready = 1'b0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk(core_tdo_sel, 1'b0);
        t_idcode();
        t_bypass();
        t_core();
        t_ext();
        t_sample();
        t_resets();
        t_pins();
        give_verdict();
    end

    initial begin
        #2000000;
        mismatches++;
        give_verdict();
    end
endmodule
